// [hw/pmbus_supply_command_bank.sv]
// pmbus command register bank of a four channel supply manager
// assumes decoded transactions from a framing layer on clk; output voltage and input
// sense words come from an adc on clk; the control pin is asynchronous
`timescale 1ns/1ps

module pmbus_supply_command_bank import pmbus_bank_pkg::*; #(
   parameter int STORE_COUNT = STORE_CYCLES,
   parameter int RESTORE_COUNT = RESTORE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire cmd_s cmd,
   input wire logic control_pin,
   input wire logic [15:0] input_voltage_sense_pin,
   input wire logic [CHANNELS-1:0][15:0] output_voltage_sense,
   output resp_s resp,
   output logic [CHANNELS-1:0] channel_output_enable_pin,
   output logic [CHANNELS-1:0][15:0] channel_target,
   output logic [CHANNELS-1:0] power_good,
   output logic busy
);

   typedef struct packed {
      settings_s cfg;
      settings_s nv;
      logic [7:0] channel_select;
      logic [CHANNELS-1:0][3:0] faults;
      logic input_ok;
      busy_e busy_kind;
      logic [31:0] busy_count;
      logic ctl_meta;
      logic ctl_sync;
      resp_s resp;
      logic [CHANNELS-1:0] enable;
      logic [CHANNELS-1:0][15:0] target;
      logic [CHANNELS-1:0] good;
      logic busy;
   } state_s;

   state_s s;
   state_s next_s;

   function automatic settings_s reset_settings();
      settings_s r;
      r.write_guard = RESET_WRITE_GUARD;
      r.input_on = RESET_INPUT_ON;
      r.input_off = RESET_INPUT_OFF;
      for (int c = 0; c < CHANNELS; c++) begin
         r.pages[c].mode = RESET_OPERATING_MODE;
         r.pages[c].enable_source = RESET_ENABLE_SOURCE;
         r.pages[c].ov_action = RESET_OV_ACTION;
         r.pages[c].setpoint = RESET_SETPOINT;
         r.pages[c].ceiling = RESET_CEILING;
         r.pages[c].margin_high = RESET_MARGIN_HIGH;
         r.pages[c].margin_low = RESET_MARGIN_LOW;
         r.pages[c].sense_res = RESET_SENSE_RES;
         r.pages[c].ov_fault = RESET_OV_FAULT;
         r.pages[c].ov_warn = RESET_OV_WARN;
         r.pages[c].uv_warn = RESET_UV_WARN;
         r.pages[c].uv_fault = RESET_UV_FAULT;
      end
      return r;
   endfunction

   function automatic state_s reset_state();
      state_s r;
      r = '0;
      r.cfg = reset_settings();
      r.nv = reset_settings();
      r.channel_select = RESET_CHANNEL_SELECT;
      r.busy_kind = IDLE;
      return r;
   endfunction

   // which codes a given write guard level still lets through
   function automatic logic write_allowed(logic [7:0] code, logic [7:0] guard);
      logic ok;
      ok = 1'b1;
      if (code != CODE_WRITE_GUARD) begin
         if (|(guard & GUARD_ALL)) begin
            ok = 1'b0;
         end else if (|(guard & GUARD_KEEP_MODE)) begin
            ok = (code == CODE_CHANNEL_SELECT) || (code == CODE_OPERATING_MODE);
         end else if (|(guard & GUARD_KEEP_SETPOINT)) begin
            ok = (code == CODE_CHANNEL_SELECT) || (code == CODE_OPERATING_MODE) ||
                 (code == CODE_ENABLE_SOURCE) || (code == CODE_SETPOINT);
         end
      end
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // command handling, nonvolatile copy, supervision

   always_comb begin
      logic [1:0] ch;
      logic clear_req;
      logic is_word;
      logic is_byte;
      logic [3:0] seen;
      logic [15:0] chosen;
      logic src_ok;
      page_regs_s pg;
      ch = '0;
      clear_req = 1'b0;
      is_word = 1'b0;
      is_byte = 1'b0;
      seen = '0;
      chosen = '0;
      src_ok = 1'b0;
      pg = '0;
      next_s = s;
      next_s.resp = '0;
      next_s.ctl_meta = control_pin;
      next_s.ctl_sync = s.ctl_meta;
      ch = s.channel_select[1:0];
      pg = s.cfg.pages[ch];
      is_word = (cmd.op == OP_WRITE_WORD);
      is_byte = (cmd.op == OP_WRITE_BYTE);

      if (s.busy_kind != IDLE) begin
         next_s.busy_count = s.busy_count - 32'h1;
         if (s.busy_count == 32'h1) begin
            next_s.busy_kind = IDLE;
            if (s.busy_kind == RESTORING) begin
               next_s.cfg = s.nv; // R7
            end
         end
      end

      if (cmd.valid) begin
         next_s.resp.valid = 1'b1;
         next_s.resp.nack = 1'b1;
         if (s.busy_kind != IDLE) begin
            if (cmd.op == OP_READ && cmd.code == CODE_BUSY_SUMMARY) begin // R22
               next_s.resp.nack = 1'b0;
               next_s.resp.data[BUSY_BIT] = 1'b1;
               next_s.resp.data[INPUT_OK_BIT] = s.input_ok;
            end
         end else if (cmd.op == OP_READ) begin
            next_s.resp.nack = 1'b0;
            unique case (cmd.code)
               CODE_CHANNEL_SELECT: next_s.resp.data = {8'h00, s.channel_select}; // R1
               CODE_OPERATING_MODE: next_s.resp.data = {8'h00, pg.mode}; // R2
               CODE_ENABLE_SOURCE: next_s.resp.data = {8'h00, pg.enable_source}; // R3
               CODE_WRITE_GUARD: next_s.resp.data = {8'h00, s.cfg.write_guard}; // R5
               CODE_PROTOCOL_FEATURES: next_s.resp.data = {8'h00, PROTOCOL_FEATURES}; // R8
               CODE_VOLTAGE_FORMAT: next_s.resp.data = {8'h00, VOLTAGE_FORMAT}; // R9
               CODE_SETPOINT: next_s.resp.data = pg.setpoint; // R10
               CODE_CEILING: next_s.resp.data = pg.ceiling; // R11
               CODE_MARGIN_HIGH: next_s.resp.data = pg.margin_high; // R12
               CODE_MARGIN_LOW: next_s.resp.data = pg.margin_low; // R13
               CODE_INPUT_ON: next_s.resp.data = s.cfg.input_on; // R14
               CODE_INPUT_OFF: next_s.resp.data = s.cfg.input_off; // R15
               CODE_SENSE_RES: next_s.resp.data = pg.sense_res; // R16
               CODE_OV_FAULT: next_s.resp.data = pg.ov_fault; // R17
               CODE_OV_ACTION: next_s.resp.data = {8'h00, pg.ov_action}; // R18
               CODE_OV_WARN: next_s.resp.data = pg.ov_warn; // R19
               CODE_UV_WARN: next_s.resp.data = pg.uv_warn; // R20
               CODE_UV_FAULT: next_s.resp.data = pg.uv_fault; // R21
               CODE_BUSY_SUMMARY: next_s.resp.data[INPUT_OK_BIT] = s.input_ok;
               CODE_FAULT_STATUS: next_s.resp.data = {12'h000, s.faults[ch]};
               default: next_s.resp.nack = 1'b1;
            endcase
         end else if (cmd.op == OP_SEND) begin
            if (cmd.code == CODE_CLEAR_FAULTS) begin
               next_s.resp.nack = 1'b0;
               clear_req = 1'b1; // R4 R23
            end else if (cmd.code == CODE_STORE_ALL) begin
               next_s.resp.nack = 1'b0;
               next_s.nv = s.cfg; // R6
               next_s.busy_kind = STORING; // R22
               next_s.busy_count = 32'(STORE_COUNT);
            end else if (cmd.code == CODE_RESTORE_ALL) begin
               next_s.resp.nack = 1'b0;
               next_s.busy_kind = RESTORING; // R7
               next_s.busy_count = 32'(RESTORE_COUNT);
            end
         end else if (write_allowed(cmd.code, s.cfg.write_guard)) begin
            next_s.resp.nack = 1'b0;
            unique case (cmd.code)
               CODE_CHANNEL_SELECT: begin
                  if (is_byte && cmd.data[7:0] < 8'(CHANNELS)) begin
                     next_s.channel_select = cmd.data[7:0]; // R1
                  end else begin
                     next_s.resp.nack = 1'b1;
                  end
               end
               CODE_WRITE_GUARD: begin
                  if (is_byte) next_s.cfg.write_guard = cmd.data[7:0]; // R5
                  else next_s.resp.nack = 1'b1;
               end
               CODE_INPUT_ON: begin
                  if (is_word) next_s.cfg.input_on = cmd.data; // R14
                  else next_s.resp.nack = 1'b1;
               end
               CODE_INPUT_OFF: begin
                  if (is_word) next_s.cfg.input_off = cmd.data; // R15
                  else next_s.resp.nack = 1'b1;
               end
               CODE_OPERATING_MODE, CODE_ENABLE_SOURCE, CODE_OV_ACTION: begin
                  if (!is_byte) next_s.resp.nack = 1'b1;
                  else if (cmd.code == CODE_OPERATING_MODE) pg.mode = cmd.data[7:0]; // R2
                  else if (cmd.code == CODE_ENABLE_SOURCE) pg.enable_source = cmd.data[7:0]; // R3
                  else pg.ov_action = cmd.data[7:0]; // R18
               end
               CODE_SETPOINT, CODE_CEILING, CODE_MARGIN_HIGH, CODE_MARGIN_LOW,
               CODE_SENSE_RES, CODE_OV_FAULT, CODE_OV_WARN, CODE_UV_WARN,
               CODE_UV_FAULT: begin
                  if (!is_word) next_s.resp.nack = 1'b1;
                  else if (cmd.code == CODE_SETPOINT) pg.setpoint = cmd.data; // R10
                  else if (cmd.code == CODE_CEILING) pg.ceiling = cmd.data; // R11
                  else if (cmd.code == CODE_MARGIN_HIGH) pg.margin_high = cmd.data; // R12
                  else if (cmd.code == CODE_MARGIN_LOW) pg.margin_low = cmd.data; // R13
                  else if (cmd.code == CODE_SENSE_RES) pg.sense_res = cmd.data; // R16
                  else if (cmd.code == CODE_OV_FAULT) pg.ov_fault = cmd.data; // R17
                  else if (cmd.code == CODE_OV_WARN) pg.ov_warn = cmd.data; // R19
                  else if (cmd.code == CODE_UV_WARN) pg.uv_warn = cmd.data; // R20
                  else pg.uv_fault = cmd.data; // R21
               end
               default: next_s.resp.nack = 1'b1;
            endcase
            next_s.cfg.pages[ch] = pg; // R24
         end
      end

      // input hysteresis between turn-on and turn-off thresholds
      if (input_voltage_sense_pin > s.cfg.input_on) begin
         next_s.input_ok = 1'b1; // R14
      end else if (input_voltage_sense_pin < s.cfg.input_off) begin
         next_s.input_ok = 1'b0; // R15
      end

      for (int c = 0; c < CHANNELS; c++) begin
         // voltages compare as unsigned mantissas of one shared exponent
         seen[FLT_OV_FAULT] = output_voltage_sense[c] > s.cfg.pages[c].ov_fault; // R17 R25
         seen[FLT_OV_WARN] = output_voltage_sense[c] > s.cfg.pages[c].ov_warn; // R19
         seen[FLT_UV_WARN] = s.enable[c] &&
                             output_voltage_sense[c] < s.cfg.pages[c].uv_warn; // R20
         seen[FLT_UV_FAULT] = s.enable[c] &&
                              output_voltage_sense[c] < s.cfg.pages[c].uv_fault; // R21
         // a new event in the clearing cycle survives the clear
         next_s.faults[c] = clear_req ? seen : (s.faults[c] | seen); // R4

         unique case (s.cfg.pages[c].mode[MODE_MARGIN_LSB +: 2])
            MARGIN_HIGH: chosen = s.cfg.pages[c].margin_high; // R12
            MARGIN_LOW: chosen = s.cfg.pages[c].margin_low; // R13
            default: chosen = s.cfg.pages[c].setpoint; // R10
         endcase
         if (chosen > s.cfg.pages[c].ceiling) begin
            chosen = s.cfg.pages[c].ceiling; // R11
         end
         next_s.target[c] = chosen;

         src_ok = 1'b1;
         if (s.cfg.pages[c].enable_source[SRC_USE_BIT]) begin // R3
            src_ok = (!s.cfg.pages[c].enable_source[SRC_NEED_MODE_BIT] ||
                      s.cfg.pages[c].mode[MODE_ON_BIT]) &&
                     (!s.cfg.pages[c].enable_source[SRC_NEED_PIN_BIT] ||
                      (s.ctl_sync == s.cfg.pages[c].enable_source[SRC_PIN_HIGH_BIT]));
         end
         next_s.enable[c] = src_ok && s.input_ok && // R14 R15
                            !(s.faults[c][FLT_OV_FAULT] &&
                              s.cfg.pages[c].ov_action[ACTION_SHUTDOWN_BIT]); // R18
         next_s.good[c] = s.enable[c] &&
                          output_voltage_sense[c] > s.cfg.pages[c].uv_fault; // R21
      end
      next_s.busy = (next_s.busy_kind != IDLE); // R22
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register and outputs

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= reset_state();
      end else begin
         s <= next_s;
      end
   end

   assign resp = s.resp;
   assign channel_output_enable_pin = s.enable;
   assign channel_target = s.target;
   assign power_good = s.good;
   assign busy = s.busy;

endmodule

// [hw/pmbus_bank_pkg.sv]
// constants, command codes, reset values and carrier types of the supply command bank
// assumes a framing layer on the same clock that delivers decoded pmbus transactions
// Behaviour
// R1: unpaged channel select at 0x00, reset 0x00
// R2: paged operating mode byte at 0x01, reset 0x00
// R3: paged enable source byte at 0x02, default 0x1e
// R4: send byte 0x03 clears all set fault bits
// R5: unpaged write guard byte at 0x10, reset 0x00
// R6: send byte 0x15 copies settings to nonvolatile store
// R7: send byte 0x16 reloads settings from nonvolatile store
// R8: read byte 0x19 returns constant 0xb0
// R9: paged read byte 0x20 returns 0x13
// R10: paged setpoint word 0x21, default 0x2000, servo target
// R11: paged ceiling word 0x24 caps every commanded target
// R12: paged margin high word 0x25, default 0x219a
// R13: paged margin low word 0x26, default 0x1e66
// R14: conversion enabled only above turn-on threshold 0x35
// R15: conversion disabled below turn-off threshold 0x36
// R16: paged sense resistance word 0x38, default 0xba00
// R17: paged overvoltage fault limit 0x40 raises fault
// R18: paged overvoltage action byte 0x41, default 0x80
// R19: paged overvoltage warning limit 0x42 flags warning
// R20: paged undervoltage warning limit 0x43 flags warning
// R21: undervoltage fault limit 0x44 drops power good
// R22: store in progress nacks all but busy read
// R23: after clear faults flags may lag 500us
// R24: paged values kept per channel, unpaged shared
// R25: voltage words are unsigned mantissa times 2^-13

package pmbus_bank_pkg;

   localparam int CHANNELS = 4;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RESTORE_TIME_MS = 30;
   localparam int RESTORE_CYCLES = RESTORE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int STORE_TIME_MS = 20;
   localparam int STORE_CYCLES = STORE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CLEAR_LAG_US = 500;

   localparam logic [7:0] CODE_CHANNEL_SELECT = 8'h00;
   localparam logic [7:0] CODE_OPERATING_MODE = 8'h01;
   localparam logic [7:0] CODE_ENABLE_SOURCE = 8'h02;
   localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CODE_WRITE_GUARD = 8'h10;
   localparam logic [7:0] CODE_STORE_ALL = 8'h15;
   localparam logic [7:0] CODE_RESTORE_ALL = 8'h16;
   localparam logic [7:0] CODE_PROTOCOL_FEATURES = 8'h19;
   localparam logic [7:0] CODE_VOLTAGE_FORMAT = 8'h20;
   localparam logic [7:0] CODE_SETPOINT = 8'h21;
   localparam logic [7:0] CODE_CEILING = 8'h24;
   localparam logic [7:0] CODE_MARGIN_HIGH = 8'h25;
   localparam logic [7:0] CODE_MARGIN_LOW = 8'h26;
   localparam logic [7:0] CODE_INPUT_ON = 8'h35;
   localparam logic [7:0] CODE_INPUT_OFF = 8'h36;
   localparam logic [7:0] CODE_SENSE_RES = 8'h38;
   localparam logic [7:0] CODE_OV_FAULT = 8'h40;
   localparam logic [7:0] CODE_OV_ACTION = 8'h41;
   localparam logic [7:0] CODE_OV_WARN = 8'h42;
   localparam logic [7:0] CODE_UV_WARN = 8'h43;
   localparam logic [7:0] CODE_UV_FAULT = 8'h44;
   localparam logic [7:0] CODE_BUSY_SUMMARY = 8'h80;
   localparam logic [7:0] CODE_FAULT_STATUS = 8'h81;

   localparam logic [7:0] PROTOCOL_FEATURES = 8'hb0;
   localparam logic [7:0] VOLTAGE_FORMAT = 8'h13;
   localparam logic [7:0] RESET_CHANNEL_SELECT = 8'h00;
   localparam logic [7:0] RESET_OPERATING_MODE = 8'h00;
   localparam logic [7:0] RESET_ENABLE_SOURCE = 8'h1e;
   localparam logic [7:0] RESET_WRITE_GUARD = 8'h00;
   localparam logic [15:0] RESET_SETPOINT = 16'h2000;
   localparam logic [15:0] RESET_CEILING = 16'h8000;
   localparam logic [15:0] RESET_MARGIN_HIGH = 16'h219a;
   localparam logic [15:0] RESET_MARGIN_LOW = 16'h1e66;
   localparam logic [15:0] RESET_INPUT_ON = 16'hd280;
   localparam logic [15:0] RESET_INPUT_OFF = 16'hd240;
   localparam logic [15:0] RESET_SENSE_RES = 16'hba00;
   localparam logic [15:0] RESET_OV_FAULT = 16'h2333;
   localparam logic [7:0] RESET_OV_ACTION = 8'h80;
   localparam logic [15:0] RESET_OV_WARN = 16'h2266;
   localparam logic [15:0] RESET_UV_WARN = 16'h1d9a;
   localparam logic [15:0] RESET_UV_FAULT = 16'h1ccd;

   // write guard levels
   localparam logic [7:0] GUARD_ALL = 8'h80;
   localparam logic [7:0] GUARD_KEEP_MODE = 8'h40;
   localparam logic [7:0] GUARD_KEEP_SETPOINT = 8'h20;

   // operating mode, enable source and overvoltage action fields
   localparam int MODE_ON_BIT = 7;
   localparam int MODE_MARGIN_LSB = 4;
   localparam logic [1:0] MARGIN_LOW = 2'b01;
   localparam logic [1:0] MARGIN_HIGH = 2'b10;
   localparam int SRC_USE_BIT = 4;
   localparam int SRC_NEED_MODE_BIT = 3;
   localparam int SRC_NEED_PIN_BIT = 2;
   localparam int SRC_PIN_HIGH_BIT = 1;
   localparam int ACTION_SHUTDOWN_BIT = 7;

   // fault status bits and busy summary bits
   localparam int FLT_OV_FAULT = 3;
   localparam int FLT_OV_WARN = 2;
   localparam int FLT_UV_WARN = 1;
   localparam int FLT_UV_FAULT = 0;
   localparam int BUSY_BIT = 7;
   localparam int INPUT_OK_BIT = 6;

   typedef enum logic [1:0] {
      OP_SEND = 2'b00,
      OP_WRITE_BYTE = 2'b01,
      OP_WRITE_WORD = 2'b10,
      OP_READ = 2'b11
   } cmd_op_e;

   typedef enum logic [1:0] {
      IDLE = 2'b00,
      STORING = 2'b01,
      RESTORING = 2'b10
   } busy_e;

   typedef struct packed {
      logic valid;
      cmd_op_e op;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_s;

   typedef struct packed {
      logic valid;
      logic nack;
      logic [15:0] data;
   } resp_s;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] enable_source;
      logic [7:0] ov_action;
      logic [15:0] setpoint;
      logic [15:0] ceiling;
      logic [15:0] margin_high;
      logic [15:0] margin_low;
      logic [15:0] sense_res;
      logic [15:0] ov_fault;
      logic [15:0] ov_warn;
      logic [15:0] uv_warn;
      logic [15:0] uv_fault;
   } page_regs_s;

   typedef struct packed {
      page_regs_s [CHANNELS-1:0] pages;
      logic [7:0] write_guard;
      logic [15:0] input_on;
      logic [15:0] input_off;
   } settings_s;

endpackage

// [bench/pmbus_bank_checker.sv]
// port assertions of the supply command bank
// assumes the bind below and the bank package
`timescale 1ns/1ps

module pmbus_bank_checker import pmbus_bank_pkg::*; #(
   parameter int STORE_COUNT = STORE_CYCLES,
   parameter int RESTORE_COUNT = RESTORE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire cmd_s cmd,
   input wire resp_s resp,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // length of the current busy run
   int busy_len;
   always_ff @(posedge clk) begin
      if (!rst_n || !busy) busy_len <= 0;
      else busy_len <= busy_len + 1;
   end

   sequence taken(cmd_op_e o, logic [7:0] c);
      cmd.valid && !busy && cmd.op == o && cmd.code == c;
   endsequence
   sequence refused;
      resp.valid && resp.nack;
   endsequence

   //////////////////////////////////////////////////////////////
   answer_next_a: assert property (cmd.valid |=> resp.valid)
      else $error("command without answer");
   busy_nack_a: assert property (cmd.valid && busy &&
      !(cmd.op == OP_READ && cmd.code == CODE_BUSY_SUMMARY) |=> refused)
      else $error("command taken while busy");
   busy_read_a: assert property (cmd.valid && busy && cmd.op == OP_READ &&
      cmd.code == CODE_BUSY_SUMMARY |=> resp.valid && !resp.nack && resp.data[BUSY_BIT])
      else $error("busy summary not readable");
   features_a: assert property (taken(OP_READ, CODE_PROTOCOL_FEATURES) |=>
      resp.valid && !resp.nack && resp.data == {8'h00, PROTOCOL_FEATURES})
      else $error("wrong feature byte");
   format_a: assert property (taken(OP_READ, CODE_VOLTAGE_FORMAT) |=>
      resp.valid && !resp.nack && resp.data == {8'h00, VOLTAGE_FORMAT})
      else $error("wrong voltage format");
   ro_write_a: assert property (taken(OP_WRITE_BYTE, CODE_PROTOCOL_FEATURES) |=> refused)
      else $error("read only write accepted");
   bad_channel_a: assert property (taken(OP_WRITE_BYTE, CODE_CHANNEL_SELECT)
      ##0 cmd.data[7:0] >= CHANNELS |=> refused)
      else $error("bad channel accepted");
   store_busy_a: assert property (taken(OP_SEND, CODE_STORE_ALL) |=>
      resp.valid && (resp.nack || busy))
      else $error("store not busy");
   restore_busy_a: assert property (taken(OP_SEND, CODE_RESTORE_ALL) |=>
      resp.valid && (resp.nack || busy))
      else $error("restore not busy");
   busy_span_a: assert property ($fell(busy) |->
      busy_len == STORE_COUNT || busy_len == RESTORE_COUNT)
      else $error("busy run of wrong length");
endmodule

bind pmbus_supply_command_bank pmbus_bank_checker #(.STORE_COUNT(STORE_COUNT),
   .RESTORE_COUNT(RESTORE_COUNT)) pmbus_bank_checker_inst (.clk(clk), .rst_n(rst_n),
   .cmd(cmd), .resp(resp), .busy(busy));

// [bench/pmbus_host_model.sv]
// host model issuing decoded pmbus transactions
// assumes the bank answers one cycle after it takes a command
`timescale 1ns/1ps

module pmbus_host_model import pmbus_bank_pkg::*; (
   input wire logic clk,
   input wire resp_s resp,
   output cmd_s cmd
);
   localparam int CLEAR_WAIT = 3;
   logic [15:0] rdata;
   logic nacked;
   initial cmd = '0;

   // a refused command is tried again, up to tries attempts in all
   task automatic xfer(input cmd_op_e op, input logic [7:0] code,
         input logic [15:0] data, input int tries, input int gap);
      for (int t = 0; t < tries; t++) begin
         repeat (gap) @(negedge clk);
         cmd <= '{1'b1, op, code, data};
         @(negedge clk);
         cmd <= '0;
         rdata = resp.data;
         nacked = !resp.valid || resp.nack;
         @(negedge clk);
         if (!nacked) break;
      end
   endtask

   task automatic clear_faults;
      xfer(OP_SEND, CODE_CLEAR_FAULTS, 16'h0000, 1, 0);
      repeat (CLEAR_WAIT) @(negedge clk);
   endtask
endmodule

// [bench/test_pmbus_supply_command_bank.sv]
// self-checking bench of the supply command bank
// assumes the host model and the bound checker
`timescale 1ns/1ps

module test_pmbus_supply_command_bank import pmbus_bank_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic control_pin = 1'b1;
   logic [15:0] vin = 16'h0000;
   logic [CHANNELS-1:0][15:0] vout = {CHANNELS{16'h2000}};
   cmd_s cmd;
   resp_s resp;
   logic [CHANNELS-1:0] en;
   logic [CHANNELS-1:0] pg;
   logic [CHANNELS-1:0][15:0] tgt;
   logic busy;
   int fail_count = 0;
   int n_checks = 0;
   int seed = 32'h056e052c;
   logic [15:0] sp [CHANNELS];
   logic [15:0] x;
   logic [7:0] codes [18] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h21, 8'h24, 8'h25,
      8'h26, 8'h35, 8'h36, 8'h38, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
   logic [15:0] dflt [18] = '{16'h0000, 16'h0000, 16'h001e, 16'h0000, 16'h00b0, 16'h0013,
      16'h2000, 16'h8000, 16'h219a, 16'h1e66, 16'hd280, 16'hd240, 16'hba00, 16'h2333,
      16'h0080, 16'h2266, 16'h1d9a, 16'h1ccd};
   logic [15:0] vins [6] = '{16'hd280, 16'hd281, 16'hd281, 16'hd240, 16'hd23f, 16'hd281};
   logic pins [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
   logic [3:0] ens [6] = '{4'h0, 4'h4, 4'h0, 4'h4, 4'h0, 4'h4};
   logic [15:0] fv [4] = '{16'h1d99, 16'h1ccc, 16'h2267, 16'h2334};
   logic [15:0] fs [4] = '{16'h0002, 16'h0003, 16'h0004, 16'h000c};
   logic fe [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic [15:0] cl [2] = '{16'h2100, 16'h0000};
   logic [7:0] md [3] = '{8'h80, 8'ha0, 8'h90};

   always #50 clk = ~clk;

   pmbus_supply_command_bank #(.STORE_COUNT(8), .RESTORE_COUNT(12))
         pmbus_supply_command_bank_inst (.clk(clk), .rst_n(rst_n), .cmd(cmd),
      .control_pin(control_pin), .input_voltage_sense_pin(vin), .output_voltage_sense(vout),
      .resp(resp), .channel_output_enable_pin(en), .channel_target(tgt), .power_good(pg),
      .busy(busy));
   pmbus_host_model pmbus_host_model_inst (.clk(clk), .resp(resp), .cmd(cmd));

   //////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results;
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic put(input cmd_op_e op, input logic [7:0] c, input logic [15:0] d,
         input logic e);
      pmbus_host_model_inst.xfer(op, c, d, 1, 0);
      chk($sformatf("refusal of %h", c), {15'h0, pmbus_host_model_inst.nacked}, {15'h0, e});
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      pmbus_host_model_inst.xfer(OP_READ, c, 16'h0000, 1, 0);
      chk($sformatf("read of %h", c), pmbus_host_model_inst.rdata, e);
   endtask

   // margin mode picks the target, the ceiling caps it
   function automatic logic [15:0] tgt_exp(logic [7:0] m, logic [15:0] s, logic [15:0] ceil);
      logic [15:0] t;
      t = (m[5:4] == 2'b10) ? 16'h219a : (m[5:4] == 2'b01) ? 16'h1e66 : s;
      return (t > ceil) ? ceil : t;
   endfunction

   //////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 18; i++)
         rd(codes[i], dflt[i]);
      chk("target", tgt[0], 16'h2000);
      foreach (sp[c]) begin
         sp[c] = $random(seed);
         put(OP_WRITE_BYTE, 8'h00, 16'(c), 1'b0);
         put(OP_WRITE_WORD, 8'h21, sp[c], 1'b0);
      end
      put(OP_WRITE_BYTE, 8'h10, 16'h0020, 1'b0);
      foreach (sp[c]) begin
         put(OP_WRITE_BYTE, 8'h00, 16'(c), 1'b0);
         rd(8'h21, sp[c]);
         rd(8'h10, 16'h0020);
      end
      put(OP_WRITE_BYTE, 8'h10, 16'h0080, 1'b0);
      put(OP_WRITE_WORD, 8'h21, 16'h1234, 1'b1);
      put(OP_WRITE_BYTE, 8'h10, 16'h0000, 1'b0);
      rd(8'h21, sp[3]);
      put(OP_WRITE_BYTE, 8'h00, 16'h0004, 1'b1);
      put(OP_WRITE_BYTE, 8'h19, 16'h0000, 1'b1);
      put(OP_WRITE_WORD, 8'h01, 16'h0000, 1'b1);
      put(OP_READ, 8'h03, 16'h0000, 1'b1);
      repeat (4)
         put(OP_READ, 8'h60 + 8'($random(seed) & 31), 16'h0000, 1'b1);
      put(OP_WRITE_BYTE, 8'h00, 16'h0002, 1'b0);
      put(OP_WRITE_BYTE, 8'h01, 16'h0080, 1'b0);
      foreach (vins[i]) begin
         vin = vins[i];
         control_pin = pins[i];
         repeat (6) @(negedge clk);
         chk("enables", {12'h0, en}, {12'h0, ens[i]});
      end
      chk("power good", {15'h0, pg[2]}, 16'h0001);
      foreach (fv[i]) begin
         vout[2] = fv[i];
         repeat (4) @(negedge clk);
         rd(8'h81, fs[i]);
         chk("enable", {15'h0, en[2]}, {15'h0, fe[i]});
         if (i < 2)
            chk("power good", {15'h0, pg[2]}, {15'h0, i == 0});
         vout[2] = 16'h2000;
         pmbus_host_model_inst.clear_faults();
         rd(8'h81, 16'h0000);
         repeat (4) @(negedge clk);
         chk("enable", {15'h0, en[2]}, 16'h0001);
      end
      put(OP_WRITE_BYTE, 8'h41, 16'h0000, 1'b0);
      put(OP_WRITE_BYTE, 8'h02, 16'h0000, 1'b0);
      control_pin = 1'b0;
      vout[2] = 16'h2334;
      repeat (6) @(negedge clk);
      chk("free run", {15'h0, en[2]}, 16'h0001);
      vout[2] = 16'h2000;
      pmbus_host_model_inst.clear_faults();
      cl[1] = $random(seed);
      foreach (cl[j]) begin
         put(OP_WRITE_WORD, 8'h24, cl[j], 1'b0);
         foreach (md[k]) begin
            put(OP_WRITE_BYTE, 8'h01, {8'h00, md[k]}, 1'b0);
            repeat (2) @(negedge clk);
            chk("target", tgt[2], tgt_exp(md[k], sp[2], cl[j]));
         end
      end
      x = $random(seed);
      put(OP_WRITE_WORD, 8'h21, x, 1'b0);
      put(OP_SEND, 8'h15, 16'h0000, 1'b0);
      chk("busy", {15'h0, busy}, 16'h0001);
      put(OP_WRITE_WORD, 8'h21, ~x, 1'b1);
      rd(8'h80, 16'h00c0);
      pmbus_host_model_inst.xfer(OP_WRITE_WORD, 8'h21, ~x, 40, 0);
      chk("late write", {15'h0, pmbus_host_model_inst.nacked}, 16'h0000);
      put(OP_SEND, 8'h16, 16'h0000, 1'b0);
      pmbus_host_model_inst.xfer(OP_READ, 8'h21, 16'h0000, 40, 1);
      chk("restored", pmbus_host_model_inst.rdata, x);
      results();
   end

   initial begin
      repeat (20000) @(negedge clk);
      fail_count++;
      results();
   end
endmodule
